// File: rtl/spdc_pkg.sv
// shared constants and types for the simd prefix decode checker
package spdc_pkg;
  // prefix and escape byte codes
  localparam logic [7:0] PFX_LOCK = 8'hf0;
  localparam logic [7:0] PFX_ASIZE = 8'h67;
  localparam logic [7:0] PFX_OSIZE = 8'h66;
  localparam logic [7:0] PFX_REPNE = 8'hf2;
  localparam logic [7:0] PFX_REP = 8'hf3;
  localparam logic [7:0] PFX_SEG_ES = 8'h26;
  localparam logic [7:0] PFX_SEG_CS = 8'h2e;
  localparam logic [7:0] PFX_SEG_SS = 8'h36;
  localparam logic [7:0] PFX_SEG_DS = 8'h3e;
  localparam logic [7:0] PFX_SEG_FS = 8'h64;
  localparam logic [7:0] PFX_SEG_GS = 8'h65;
  localparam logic [7:0] PFX_BR_NT = 8'he2;
  localparam logic [7:0] PFX_BR_T = 8'he3;
  localparam logic [7:0] ESC_TWO_BYTE = 8'h0f;
  // segment indices in the segment base vector
  localparam logic [2:0] SEG_ES = 3'h0;
  localparam logic [2:0] SEG_CS = 3'h1;
  localparam logic [2:0] SEG_SS = 3'h2;
  localparam logic [2:0] SEG_DS = 3'h3;
  localparam logic [2:0] SEG_FS = 3'h4;
  localparam logic [2:0] SEG_GS = 3'h5;
  // widths and counts
  localparam int VEC_W = 128;
  localparam int VEC_BYTES = 16;
  localparam int ADDR_W = 32;
  localparam int ADDR16_W = 16;
  localparam int GPR_W = 32;
  localparam int SEG_CNT = 6;
  localparam int PFX_MAX = 4;
  localparam int ALIGN_BITS = 4;
  localparam int FLAGS_W = 3;
  localparam logic [7:0] MAX_BSHIFT = 8'h0f;
  // integer flag bit positions
  localparam int FL_ZF = 2;
  localparam int FL_PF = 1;
  localparam int FL_CF = 0;
  // double precision field positions
  localparam int DBL_SIGN = 63;
  localparam int DBL_EXP_LO = 52;
  localparam int DBL_QBIT = 51;
  localparam int DBL_HI_SIGN = 127;
  // mandatory prefix selection
  typedef enum logic [1:0] {MAND_NONE, MAND_66, MAND_F3, MAND_F2} spdc_mand_t;
  // operation classes from the opcode table
  typedef enum logic [3:0] {
    OP_NOP, OP_PADD, OP_PCMPEQ, OP_MASKPD, OP_COMI, OP_UCOMI, OP_BSHL,
    OP_BSHR, OP_LOADU, OP_PREFETCH, OP_STREAM, OP_STORE_FENCE, OP_FULL_MEMORY_FENCE
  } spdc_op_t;
  // sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FENCE} spdc_state_t;
endpackage

// File: rtl/spdc_vec_alu.sv
// combinational 128-bit vector datapath for the checker
`timescale 1ns/10ps
`default_nettype none
module spdc_vec_alu
  import spdc_pkg::*;
(
  // operands
  input wire logic [VEC_W-1:0] opA,
  input wire logic [VEC_W-1:0] opB,
  input wire logic [1:0] elemSize,
  input wire logic [7:0] shiftCnt,
  // results
  output logic [VEC_W-1:0] sumOut,
  output logic [VEC_W-1:0] cmpMask,
  output logic [VEC_W-1:0] shlOut,
  output logic [VEC_W-1:0] shrOut,
  output logic [1:0] maskBits,
  output logic [FLAGS_W-1:0] cmpFlags,
  output logic cmpNan,
  output logic cmpSnan
);
  // carry chain, broken at element boundaries
  logic [VEC_BYTES:0] carry;
  logic [VEC_BYTES-1:0] byteEq;
  logic [3:0] laneMask;
  logic grpEq;
  logic aNan, bNan, aSnan, bSnan, less;
  logic [DBL_SIGN-1:0] aMag, bMag;

  // low bits of byte index that stay inside one element
  assign laneMask = 4'((5'h01 << elemSize) - 5'h01);
  assign carry[0] = 1'b0;

  // per-byte adder slice; same lane function as the 64-bit form
  for (genvar gi = 0; gi < VEC_BYTES; gi++) begin : g_byte
    logic boundary;
    logic cin;
    assign boundary = ((4'(gi) & laneMask) == 4'h0);
    assign cin = boundary ? 1'b0 : carry[gi];
    assign {carry[gi+1], sumOut[gi*8 +: 8]} =
      {1'b0, opA[gi*8 +: 8]} + {1'b0, opB[gi*8 +: 8]} + {8'h00, cin};
    assign byteEq[gi] = (opA[gi*8 +: 8] == opB[gi*8 +: 8]);
  end

  // element equality widened to an all-ones or all-zeros mask
  always_comb begin
    grpEq = 1'b1;
    for (int i = 0; i < VEC_BYTES; i++) begin
      grpEq = 1'b1;
      for (int j = 0; j < VEC_BYTES; j++) begin
        if ((j >> elemSize) == (i >> elemSize)) begin
          grpEq = grpEq & byteEq[j];
        end
      end
      cmpMask[i*8 +: 8] = {8{grpEq}};
    end
  end

  // whole-register byte shifts; counts past fifteen clear all
  always_comb begin
    if (shiftCnt > MAX_BSHIFT) begin
      shlOut = '0;
      shrOut = '0;
    end else begin
      shlOut = opA << {shiftCnt[3:0], 3'h0};
      shrOut = opA >> {shiftCnt[3:0], 3'h0};
    end
  end

  // top bit of each double element
  assign maskBits = {opA[DBL_HI_SIGN], opA[DBL_SIGN]};

  // scalar double compare on the low element
  assign aMag = opA[DBL_SIGN-1:0];
  assign bMag = opB[DBL_SIGN-1:0];
  assign aNan = (&opA[DBL_SIGN-1:DBL_EXP_LO]) && (|opA[DBL_QBIT:0]);
  assign bNan = (&opB[DBL_SIGN-1:DBL_EXP_LO]) && (|opB[DBL_QBIT:0]);
  assign aSnan = aNan && !opA[DBL_QBIT];
  assign bSnan = bNan && !opB[DBL_QBIT];
  assign cmpNan = aNan || bNan;
  assign cmpSnan = aSnan || bSnan;

  // signed-magnitude ordering, both zeros compare equal
  always_comb begin
    less = 1'b0;
    cmpFlags = '0;
    if (opA[DBL_SIGN] && !opB[DBL_SIGN]) begin
      less = 1'b1;
    end else if (!opA[DBL_SIGN] && opB[DBL_SIGN]) begin
      less = 1'b0;
    end else if (opA[DBL_SIGN]) begin
      less = aMag > bMag;
    end else begin
      less = aMag < bMag;
    end
    if (cmpNan) begin
      cmpFlags = '1; // unordered sets all three
    end else if ((aMag == bMag) && ((opA[DBL_SIGN] == opB[DBL_SIGN]) ||
                 (aMag == '0))) begin
      cmpFlags[FL_ZF] = 1'b1;
    end else if (less) begin
      cmpFlags[FL_CF] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: rtl/spdc_prefix_checker.sv
// simd prefix screening, address forming and vector execute checks
//
// Functional notes
// - lock prefix on simd op raises illegal fault
// - address-size prefix toggles memory operand width
// - segment override picks operand segment base
// - those prefixes without memory operand: ignored, flagged
// - stray repeat, hint, operand-size prefixes: flagged only
// - mandatory prefix before escape byte selects form
// - misaligned packed integer memory operand: protection fault
// - unaligned vector load never faults
// - wide lanes use same per-element arithmetic
// - byte shifts move whole 128-bit vector
// - packed compare writes mask, never flags
// - mask extract packs two double top bits
// - scalar double compares update integer flags
// - prefetch hints change no architectural result
// - streaming stores carry no-allocate marking
// - fences hold later stores until earlier visible
`timescale 1ns/10ps
`default_nettype none
module spdc_prefix_checker
  import spdc_pkg::*;
#(
  parameter int NUM_PREFIX = PFX_MAX
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction from the fetch front end
  input wire logic instValid,
  input wire logic [NUM_PREFIX*8-1:0] prefixBytes,
  input wire logic [2:0] prefixCount,
  input wire logic [7:0] escapeByte,
  input wire spdc_op_t opKind,
  input wire logic memOperand,
  input wire logic [1:0] elemSize,
  input wire logic [7:0] shiftCount,
  input wire logic [VEC_W-1:0] srcA,
  input wire logic [VEC_W-1:0] srcB,
  input wire logic [ADDR_W-1:0] effOffset,
  input wire logic addrMode16,
  input wire logic [2:0] defaultSeg,
  input wire logic [SEG_CNT*ADDR_W-1:0] segBases,
  output logic instReady,
  // decode report
  output logic [1:0] mandSel,
  output logic threeByte,
  output logic reservedSeen,
  // execute results
  output logic doneValid,
  output logic illegalFault,
  output logic protFault,
  output logic vecWrite,
  output logic [VEC_W-1:0] vecData,
  output logic gprWrite,
  output logic [GPR_W-1:0] gprData,
  output logic flagsWrite,
  output logic [FLAGS_W-1:0] flagsOut,
  output logic fpInvalid,
  // memory subsystem
  output logic memReq,
  output logic memWrite,
  output logic memNoAlloc,
  output logic memPrefetch,
  output logic [ADDR_W-1:0] memAddr,
  output logic [VEC_W-1:0] memWdata,
  input wire logic storesDrained
);
  // sequencer
  spdc_state_t state, stateNxt;
  logic take;
  // prefix scan results
  logic lockHit, asizeHit, segHit, resHit;
  logic [2:0] ovrSeg, useSeg;
  spdc_mand_t mandHit;
  logic [7:0] pb;
  logic use16;
  logic [ADDR_W-1:0] offEff, selBase, ovrBase, linAddr;
  // latched instruction
  spdc_op_t op_r;
  logic memOp_r, lock_r;
  logic [1:0] elem_r;
  logic [7:0] cnt_r;
  logic [VEC_W-1:0] srcA_r, srcB_r;
  logic [ADDR_W-1:0] linAddr_r;
  // output flops
  logic instReady_r, doneValid_r, illegalFault_r, protFault_r;
  logic vecWrite_r, gprWrite_r, flagsWrite_r, fpInvalid_r;
  logic memReq_r, memWrite_r, memNoAlloc_r, memPrefetch_r;
  logic threeByte_r, reservedSeen_r;
  logic [1:0] mandSel_r;
  logic [VEC_W-1:0] vecData_r, memWdata_r;
  logic [GPR_W-1:0] gprData_r;
  logic [FLAGS_W-1:0] flagsOut_r;
  logic [ADDR_W-1:0] memAddr_r;
  // datapath results
  logic [VEC_W-1:0] sumOut, cmpMask, shlOut, shrOut;
  logic [1:0] maskBits;
  logic [FLAGS_W-1:0] cmpFlags;
  logic cmpNan, cmpSnan;
  logic isFence, misalign;

  assign take = instValid && instReady_r;
  assign isFence = (op_r == OP_STORE_FENCE) || (op_r == OP_FULL_MEMORY_FENCE);

  // prefix scan; last segment override wins
  always_comb begin
    lockHit = 1'b0;
    asizeHit = 1'b0;
    segHit = 1'b0;
    resHit = 1'b0;
    ovrSeg = SEG_DS;
    mandHit = MAND_NONE;
    pb = '0;
    for (int i = 0; i < NUM_PREFIX; i++) begin
      pb = prefixBytes[i*8 +: 8];
      if (3'(i) < prefixCount) begin
        // mandatory slot: last prefix right before the escape byte
        if ((3'(i) + 3'h1 == prefixCount) && escapeByte == ESC_TWO_BYTE &&
            (pb == PFX_OSIZE || pb == PFX_REP || pb == PFX_REPNE)) begin
          if (pb == PFX_OSIZE) begin
            mandHit = MAND_66;
          end else if (pb == PFX_REP) begin
            mandHit = MAND_F3;
          end else begin
            mandHit = MAND_F2;
          end
        end else begin
          case (pb)
            PFX_LOCK: lockHit = 1'b1;
            PFX_ASIZE: asizeHit = 1'b1;
            PFX_SEG_ES: begin segHit = 1'b1; ovrSeg = SEG_ES; end
            PFX_SEG_CS: begin segHit = 1'b1; ovrSeg = SEG_CS; end
            PFX_SEG_SS: begin segHit = 1'b1; ovrSeg = SEG_SS; end
            PFX_SEG_DS: begin segHit = 1'b1; ovrSeg = SEG_DS; end
            PFX_SEG_FS: begin segHit = 1'b1; ovrSeg = SEG_FS; end
            PFX_SEG_GS: begin segHit = 1'b1; ovrSeg = SEG_GS; end
            // stray repeat, operand-size and hint bytes
            PFX_OSIZE, PFX_REP, PFX_REPNE,
            PFX_BR_NT, PFX_BR_T: resHit = 1'b1;
            default: ;
          endcase
        end
      end
    end
    // register-only form: prefixes ignored, just reported
    if (!memOperand && (asizeHit || segHit)) begin
      resHit = 1'b1;
    end
  end

  // effective address width and segment for memory forms only
  assign use16 = addrMode16 ^ (asizeHit && memOperand);
  assign offEff = use16 ? {{(ADDR_W-ADDR16_W){1'b0}},
                           effOffset[ADDR16_W-1:0]} : effOffset;
  assign useSeg = (segHit && memOperand) ? ovrSeg : defaultSeg;
  assign selBase = segBases[useSeg*ADDR_W +: ADDR_W];
  assign ovrBase = segBases[ovrSeg*ADDR_W +: ADDR_W];
  assign linAddr = selBase + offEff;

  // next state; a fence waits for the store drain
  always_comb begin
    stateNxt = state;
    case (state)
      ST_IDLE: if (take) stateNxt = ST_EXEC;
      ST_EXEC: stateNxt = (isFence && !lock_r) ? ST_FENCE : ST_IDLE;
      ST_FENCE: if (storesDrained) stateNxt = ST_IDLE;
      default: stateNxt = ST_IDLE;
    endcase
  end

  // state register and front-end ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      instReady_r <= 1'b1;
    end else begin
      state <= stateNxt;
      instReady_r <= (stateNxt == ST_IDLE);
    end
  end

  // decode latch; prefix screening done here, alignment checked at execute, before any access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= OP_NOP;
      memOp_r <= 1'b0;
      lock_r <= 1'b0;
      elem_r <= '0;
      cnt_r <= '0;
      srcA_r <= '0;
      srcB_r <= '0;
      linAddr_r <= '0;
      mandSel_r <= MAND_NONE;
      threeByte_r <= 1'b0;
      reservedSeen_r <= 1'b0;
    end else if (take) begin
      op_r <= opKind;
      memOp_r <= memOperand;
      lock_r <= lockHit;
      elem_r <= elemSize;
      cnt_r <= shiftCount;
      srcA_r <= srcA;
      srcB_r <= srcB;
      linAddr_r <= linAddr;
      mandSel_r <= mandHit;
      threeByte_r <= (mandHit != MAND_NONE);
      reservedSeen_r <= resHit;
    end
  end

  // alignment only matters for packed integer memory forms
  assign misalign = memOp_r && ((op_r == OP_PADD) || (op_r == OP_PCMPEQ))
                    && (linAddr_r[ALIGN_BITS-1:0] != '0);

  spdc_vec_alu u_alu (
    .opA(srcA_r),
    .opB(srcB_r),
    .elemSize(elem_r),
    .shiftCnt(cnt_r),
    .sumOut(sumOut),
    .cmpMask(cmpMask),
    .shlOut(shlOut),
    .shrOut(shrOut),
    .maskBits(maskBits),
    .cmpFlags(cmpFlags),
    .cmpNan(cmpNan),
    .cmpSnan(cmpSnan)
  );

  // one-cycle strobes of the execute step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      doneValid_r <= 1'b0;
      illegalFault_r <= 1'b0;
      protFault_r <= 1'b0;
      vecWrite_r <= 1'b0;
      gprWrite_r <= 1'b0;
      flagsWrite_r <= 1'b0;
      fpInvalid_r <= 1'b0;
      memReq_r <= 1'b0;
      memWrite_r <= 1'b0;
      memNoAlloc_r <= 1'b0;
      memPrefetch_r <= 1'b0;
    end else begin
      doneValid_r <= (state == ST_EXEC);
      illegalFault_r <= 1'b0;
      protFault_r <= 1'b0;
      vecWrite_r <= 1'b0;
      gprWrite_r <= 1'b0;
      flagsWrite_r <= 1'b0;
      fpInvalid_r <= 1'b0;
      memReq_r <= 1'b0;
      memWrite_r <= 1'b0;
      memNoAlloc_r <= 1'b0;
      memPrefetch_r <= 1'b0;
      if (state == ST_EXEC) begin
        if (lock_r) begin
          illegalFault_r <= 1'b1;
        end else if (misalign) begin
          protFault_r <= 1'b1;
        end else begin
          case (op_r)
            OP_PADD, OP_PCMPEQ, OP_BSHL, OP_BSHR: vecWrite_r <= 1'b1;
            OP_MASKPD: gprWrite_r <= 1'b1;
            OP_COMI: begin
              flagsWrite_r <= 1'b1;
              fpInvalid_r <= cmpNan;
            end
            OP_UCOMI: begin
              flagsWrite_r <= 1'b1;
              fpInvalid_r <= cmpSnan;
            end
            OP_LOADU: memReq_r <= 1'b1;
            // hint only: no register or flag write
            OP_PREFETCH: begin
              memReq_r <= 1'b1;
              memPrefetch_r <= 1'b1;
            end
            OP_STREAM: begin
              memReq_r <= 1'b1;
              memWrite_r <= 1'b1;
              memNoAlloc_r <= 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // held result and address values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vecData_r <= '0;
      gprData_r <= '0;
      flagsOut_r <= '0;
      memAddr_r <= '0;
      memWdata_r <= '0;
    end else if (state == ST_EXEC && !lock_r && !misalign) begin
      case (op_r)
        OP_PADD: vecData_r <= sumOut;
        OP_PCMPEQ: vecData_r <= cmpMask;
        OP_BSHL: vecData_r <= shlOut;
        OP_BSHR: vecData_r <= shrOut;
        OP_MASKPD: gprData_r <= {{(GPR_W-2){1'b0}}, maskBits};
        OP_COMI, OP_UCOMI: flagsOut_r <= cmpFlags;
        OP_LOADU, OP_PREFETCH: memAddr_r <= linAddr_r;
        OP_STREAM: begin
          memAddr_r <= linAddr_r;
          memWdata_r <= srcA_r;
        end
        default: ;
      endcase
    end
  end

  assign instReady = instReady_r;
  assign mandSel = mandSel_r;
  assign threeByte = threeByte_r;
  assign reservedSeen = reservedSeen_r;
  assign doneValid = doneValid_r;
  assign illegalFault = illegalFault_r;
  assign protFault = protFault_r;
  assign vecWrite = vecWrite_r;
  assign vecData = vecData_r;
  assign gprWrite = gprWrite_r;
  assign gprData = gprData_r;
  assign flagsWrite = flagsWrite_r;
  assign flagsOut = flagsOut_r;
  assign fpInvalid = fpInvalid_r;
  assign memReq = memReq_r;
  assign memWrite = memWrite_r;
  assign memNoAlloc = memNoAlloc_r;
  assign memPrefetch = memPrefetch_r;
  assign memAddr = memAddr_r;
  assign memWdata = memWdata_r;

  // fence steps
  sequence s_fenceIssue;
    state == ST_EXEC && isFence && !lock_r;
  endsequence
  sequence s_drainWait;
    !storesDrained;
  endsequence

  a_lock_faults: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_EXEC && lock_r |=> illegalFault && !vecWrite && !memReq
      && !gprWrite && !flagsWrite)
    else $error("lock prefix did not fault cleanly");
  a_addr_width: assert property (@(posedge clk) disable iff (!rst_n)
    take && memOperand && asizeHit && !addrMode16 |=> linAddr_r ==
      $past(selBase) + {16'h0000, $past(effOffset[ADDR16_W-1:0])})
    else $error("address size prefix not applied");
  a_seg_select: assert property (@(posedge clk) disable iff (!rst_n)
    take && memOperand && segHit |=>
      linAddr_r == $past(ovrBase) + $past(offEff))
    else $error("segment override not applied");
  a_nomem_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    take && !memOperand && prefixCount == 3'h1 &&
      prefixBytes[7:0] == PFX_ASIZE |=> reservedSeen)
    else $error("register form prefix not reported");
  a_hint_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    take && prefixCount == 3'h1 && prefixBytes[7:1] == PFX_BR_T[7:1]
      |=> reservedSeen && !threeByte)
    else $error("hint prefix not reported");
  a_mand_select: assert property (@(posedge clk) disable iff (!rst_n)
    take && escapeByte == ESC_TWO_BYTE && prefixCount == 3'h1 &&
      prefixBytes[7:0] == PFX_REP |=> mandSel == MAND_F3 && threeByte)
    else $error("mandatory prefix not selected");
  a_misalign_gp: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_EXEC && !lock_r && memOp_r && op_r == OP_PADD &&
      linAddr_r[ALIGN_BITS-1:0] != '0 |=> protFault && !vecWrite)
    else $error("misaligned packed operand not faulted");
  a_loadu_nofault: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_EXEC && !lock_r && op_r == OP_LOADU |=> memReq &&
      !memWrite && !protFault && memAddr == $past(linAddr_r))
    else $error("unaligned load faulted or lost");
  a_lane_add: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_EXEC && !lock_r && !misalign && op_r == OP_PADD |=>
      vecData[7:0] == 8'($past(srcA_r[7:0]) + $past(srcB_r[7:0])))
    else $error("lane add wrong");
  a_byte_shift: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_EXEC && !lock_r && op_r == OP_BSHL && cnt_r == 8'h03
      |=> vecData == {$past(srcA_r[VEC_W-25:0]), 24'h000000})
    else $error("byte shift wrong");
  a_cmp_noflags: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_EXEC && op_r == OP_PCMPEQ |=> !flagsWrite &&
      $stable(flagsOut))
    else $error("packed compare touched flags");
  a_mask_extract: assert property (@(posedge clk) disable iff (!rst_n)
    gprWrite |-> gprData[GPR_W-1:2] == '0 && gprData[1:0] ==
      {$past(srcA_r[DBL_HI_SIGN]), $past(srcA_r[DBL_SIGN])})
    else $error("mask extract wrong");
  a_scalar_flags: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_EXEC && !lock_r && op_r == OP_COMI |=> flagsWrite
      && doneValid)
    else $error("scalar compare did not write flags");
  a_prefetch_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_EXEC && op_r == OP_PREFETCH |=> !vecWrite && !gprWrite
      && !flagsWrite && !memWrite)
    else $error("prefetch changed visible state");
  a_stream_noalloc: assert property (@(posedge clk) disable iff (!rst_n)
    memReq && memWrite |-> memNoAlloc)
    else $error("streaming store allocates");
  a_fence_order: assert property (@(posedge clk) disable iff (!rst_n)
    s_fenceIssue ##1 s_drainWait |=> !instReady && !memReq)
    else $error("fence released before drain");
  a_mask_full: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_EXEC && !lock_r && !misalign && op_r == OP_PCMPEQ
      |=> vecData[7:0] == 8'h00 || vecData[7:0] == 8'hff)
    else $error("compare element not full mask");
endmodule
`default_nettype wire

// File: sim/spdc_mem_model.sv
// memory side model that reports when issued stores become visible
`timescale 1ns/10ps
`default_nettype none
module spdc_mem_model #(
  parameter int DRAIN = 5
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // requests from the checker
  input wire logic memReq,
  input wire logic memWrite,
  // visibility report
  output logic storesDrained
);
  // cycles left before the last store is visible; slow so fences must wait
  logic [3:0] pendCnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pendCnt_r <= 4'h0;
    end else if (memReq && memWrite) begin
      pendCnt_r <= 4'(DRAIN);
    end else if (pendCnt_r != 4'h0) begin
      pendCnt_r <= pendCnt_r - 4'h1;
    end
  end
  // low from the cycle after a store until it is visible
  assign storesDrained = (pendCnt_r == 4'h0);
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the simd prefix decode checker
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import spdc_pkg::*;
;
  // stimulus, all valued at time zero
  logic clk = 1'b0, rst_n = 1'b0, instValid = 1'b0, memOperand = 1'b0;
  logic [31:0] prefixBytes = 32'h0, effOffset = 32'h0;
  logic [2:0] prefixCount = 3'h0;
  logic [7:0] escapeByte = 8'h0f, shiftCount = 8'h00;
  logic [1:0] elemSize = 2'h0;
  logic addrMode16 = 1'b0;
  logic [127:0] srcA = 128'h0, srcB = 128'h0;
  spdc_op_t opKind = OP_NOP;
  // distinct bases so a wrong segment shows in the address
  logic [191:0] segBases = {32'h60000000, 32'h50000000, 32'h40000000,
    32'h30000000, 32'h20000000, 32'h10000000};
  // observed outputs
  logic instReady, threeByte, reservedSeen, doneValid, illegalFault;
  logic protFault, vecWrite, gprWrite, flagsWrite, fpInvalid, memReq;
  logic memWrite, memNoAlloc, memPrefetch, storesDrained;
  logic [1:0] mandSel;
  logic [127:0] vecData, memWdata;
  logic [31:0] gprData, memAddr;
  logic [2:0] flagsOut;
  int err_total = 0;
  int tests_run = 0;
  // 25 ns clock
  always #12.5 clk = ~clk;
  spdc_prefix_checker DUT (.clk(clk), .rst_n(rst_n), .instValid(instValid),
    .prefixBytes(prefixBytes), .prefixCount(prefixCount),
    .escapeByte(escapeByte), .opKind(opKind), .memOperand(memOperand),
    .elemSize(elemSize), .shiftCount(shiftCount), .srcA(srcA), .srcB(srcB),
    .effOffset(effOffset), .addrMode16(addrMode16), .defaultSeg(SEG_DS),
    .segBases(segBases), .instReady(instReady), .mandSel(mandSel),
    .threeByte(threeByte), .reservedSeen(reservedSeen),
    .doneValid(doneValid), .illegalFault(illegalFault),
    .protFault(protFault), .vecWrite(vecWrite), .vecData(vecData),
    .gprWrite(gprWrite), .gprData(gprData), .flagsWrite(flagsWrite),
    .flagsOut(flagsOut), .fpInvalid(fpInvalid), .memReq(memReq),
    .memWrite(memWrite), .memNoAlloc(memNoAlloc), .memPrefetch(memPrefetch),
    .memAddr(memAddr), .memWdata(memWdata), .storesDrained(storesDrained));
  spdc_mem_model #(.DRAIN(5)) mem (.clk(clk), .rst_n(rst_n),
    .memReq(memReq), .memWrite(memWrite), .storesDrained(storesDrained));
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one comparison, zero extended to the widest result
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait on a settled level, a hang ends the run
  task automatic wait_hi(ref logic sig);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 20) begin
      err_total++;
      complete_run();
    end
  endtask
  // offer one instruction, return in the settled done cycle
  task automatic issue(input logic [31:0] pfx, input logic [2:0] cnt,
      input spdc_op_t op, input logic mem, input logic [31:0] off);
    @(posedge clk);
    instValid <= 1'b1;
    prefixBytes <= pfx;
    prefixCount <= cnt;
    opKind <= op;
    memOperand <= mem;
    effOffset <= off;
    #1;
    wait_hi(instReady);
    @(posedge clk);
    instValid <= 1'b0;
    #1;
    wait_hi(doneValid);
  endtask
  // lock fault beats misalign; mandatory and stray prefixes
  task automatic t_prefix();
    logic [7:0] mb [3] = '{8'h66, 8'hf3, 8'hf2};
    escapeByte <= 8'h0f;
    issue(32'h000066f0, 3'h2, OP_PADD, 1'b1, 32'h00000003);
    chk(illegalFault, 1'b1);
    chk({protFault, vecWrite, memReq}, 3'h0);
    for (int i = 0; i < 3; i++) begin
      issue({24'h0, mb[i]}, 3'h1, OP_PADD, 1'b0, 32'h0);
      chk({mandSel, threeByte, reservedSeen}, {2'(i + 1), 2'h2});
    end
    issue(32'h0000f366, 3'h2, OP_PADD, 1'b0, 32'h0);
    chk({mandSel, reservedSeen, vecWrite}, {MAND_F3, 2'h3});
    issue(32'h000000e2, 3'h1, OP_PADD, 1'b0, 32'h0);
    chk({mandSel, reservedSeen, vecWrite}, 4'h3);
    issue(32'h0000002e, 3'h1, OP_PCMPEQ, 1'b0, 32'h0);
    chk({reservedSeen, memReq}, 2'h2);
    issue(32'h00000067, 3'h1, OP_PCMPEQ, 1'b0, 32'h0);
    chk({reservedSeen, memReq}, 2'h2);
    $display("test prefix done");
  endtask
  // lane widths and memory alignment of packed integer ops
  task automatic t_align();
    srcA <= {128{1'b1}};
    srcB <= {16{8'h01}};
    elemSize <= 2'h0;
    issue(32'h0, 3'h0, OP_PADD, 1'b1, 32'h00000010);
    chk({vecWrite, protFault}, 2'h2);
    chk(vecData, 128'h0);
    elemSize <= 2'h3;
    issue(32'h0, 3'h0, OP_PADD, 1'b1, 32'h00000020);
    chk(vecData, {2{64'h0101010101010100}});
    elemSize <= 2'h1;
    issue(32'h0, 3'h0, OP_PADD, 1'b1, 32'h00000030);
    chk(vecData, {8{16'h0100}});
    issue(32'h0, 3'h0, OP_PADD, 1'b1, 32'h00000018);
    chk({protFault, vecWrite, memReq}, 3'h4);
    $display("test align done");
  endtask
  // compare mask, mask extract, scalar flags, byte shifts
  task automatic t_cmp();
    elemSize <= 2'h2;
    srcA <= 128'h00000004_00000003_00000002_00000001;
    srcB <= 128'h00000004_00000009_00000002_00000001;
    issue(32'h0, 3'h0, OP_PCMPEQ, 1'b0, 32'h0);
    chk(vecData, 128'hffffffff_00000000_ffffffff_ffffffff);
    chk({vecWrite, flagsWrite}, 2'h2);
    srcA <= {1'b1, 127'h0};
    issue(32'h0, 3'h0, OP_MASKPD, 1'b0, 32'h0);
    chk({gprWrite, gprData}, {1'b1, 32'h2});
    srcA <= {64'h0, 64'h3ff0000000000000};
    srcB <= {64'h0, 64'h4000000000000000};
    issue(32'h0, 3'h0, OP_COMI, 1'b0, 32'h0);
    chk({flagsWrite, flagsOut, vecWrite, fpInvalid}, 6'h24);
    srcB <= {64'h0, 64'h3ff0000000000000};
    issue(32'h0, 3'h0, OP_UCOMI, 1'b0, 32'h0);
    chk({flagsWrite, flagsOut}, 4'hc);
    srcA <= {64'h0, 64'h7ff8000000000000};
    issue(32'h0, 3'h0, OP_COMI, 1'b0, 32'h0);
    chk({flagsOut, fpInvalid}, 4'hf);
    srcA <= 128'h0102030405060708090a0b0c0d0e0f10;
    shiftCount <= 8'h03;
    issue(32'h0, 3'h0, OP_BSHL, 1'b0, 32'h0);
    chk(vecData, 128'h0405060708090a0b0c0d0e0f10000000);
    issue(32'h0, 3'h0, OP_BSHR, 1'b0, 32'h0);
    chk(vecData, 128'h0000000102030405060708090a0b0c0d);
    $display("test compare done");
  endtask
  // address forming, loads, hints, streaming stores and fences
  task automatic t_mem();
    spdc_op_t fk [2] = '{OP_STORE_FENCE, OP_FULL_MEMORY_FENCE};
    issue(32'h00000065, 3'h1, OP_LOADU, 1'b1, 32'h00012343);
    chk({memReq, memWrite, protFault}, 3'h4);
    chk(memAddr, 32'h60012343);
    issue(32'h00006765, 3'h2, OP_LOADU, 1'b1, 32'h00012343);
    chk(memAddr, 32'h60002343);
    addrMode16 <= 1'b1;
    issue(32'h00006765, 3'h2, OP_LOADU, 1'b1, 32'h00012343);
    chk(memAddr, 32'h60012343);
    addrMode16 <= 1'b0;
    issue(32'h0, 3'h0, OP_PREFETCH, 1'b1, 32'h00000040);
    chk({memReq, memPrefetch, vecWrite, gprWrite, flagsWrite}, 5'h18);
    for (int i = 0; i < 2; i++) begin
      issue(32'h0, 3'h0, OP_STREAM, 1'b1, 32'h00000100);
      chk({memReq, memWrite, memNoAlloc, memAddr}, {3'h7, 32'h40000100});
      chk(memWdata, srcA);
      issue(32'h0, 3'h0, fk[i], 1'b0, 32'h0);
      chk({instReady, storesDrained}, 2'h0);
      wait_hi(instReady);
      chk(storesDrained, 1'b1);
    end
    $display("test memory done");
  endtask
  // reset for 8 cycles, then the scenarios
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_prefix();
    t_align();
    t_cmp();
    t_mem();
    complete_run();
  end
endmodule
`default_nettype wire
